// ==== hdl/tcc_pkg.sv ====
// Constants, register map and carrier types of the timer capture/compare unit.
// How it works
// RQ1 - Three-bit code picks counter clock source
// RQ2 - Two-bit code picks filter sampling clock
// RQ3 - Filter enable delays edge up to three samples
// RQ4 - Software changes filter clock only while stopped
// RQ5 - Run bit seven counts, zero holds count
// RQ6 - Mode bit selects capture or compare
// RQ7 - Capture edge code: rise, fall, both
// RQ8 - Valid edge copies counter into general register
// RQ9 - Before first match pin follows action code
// RQ10 - Counter equal general register means compare match
// RQ11 - Pin settings apply in timer mode only
// RQ12 - Software writes pin control only while stopped
// RQ13 - Overflow flag interrupts only when enabled
// RQ14 - Underflow flag interrupts only when enabled
// RQ15 - Unit match flags interrupt only when enabled
// RQ16 - Request flag bit three shows pending request
// RQ17 - Mask bit three zero allows servicing
// RQ18 - Two separate bits give priority level
// RQ19 - Match action: none, low, high, toggle
// RQ20 - Supply enable zero resets timer, blocks writes
// RQ21 - Counter wrap to zero sets overflow flag
package tcc_pkg;

  // Byte addresses of the APB registers
  localparam logic [7:0] TCC_OFS_CONTROL = 8'h00;   // timer_control
  localparam logic [7:0] TCC_OFS_MODE = 8'h04;      // timer_mode_control
  localparam logic [7:0] TCC_OFS_PIN_IO = 8'h08;    // timer_pin_io_control
  localparam logic [7:0] TCC_OFS_IRQ_EN = 8'h0c;    // timer_irq_enable
  localparam logic [7:0] TCC_OFS_STATUS = 8'h10;    // Status flags
  localparam logic [7:0] TCC_OFS_GEN_A = 8'h14;     // general_reg_a
  localparam logic [7:0] TCC_OFS_GEN_B = 8'h18;     // general_reg_b
  localparam logic [7:0] TCC_OFS_COUNTER = 8'h1c;   // main_counter
  localparam logic [7:0] TCC_OFS_IRQ_REQ = 8'h20;   // irq_request_flags_2h
  localparam logic [7:0] TCC_OFS_IRQ_MASK = 8'h24;  // irq_mask_flags_2h
  localparam logic [7:0] TCC_OFS_PRIO_HI = 8'h28;   // irq_priority_high_bits
  localparam logic [7:0] TCC_OFS_PRIO_LO = 8'h2c;   // irq_priority_low_bits
  localparam logic [7:0] TCC_OFS_SUPPLY = 8'h30;    // Clock supply enable

  // Field positions
  localparam int TCC_BIT_RUN = 7;        // Mode: counter_run
  localparam int TCC_BIT_FILT_SEL = 4;   // Mode: filter clock select, two bits
  localparam int TCC_BIT_FILT_B = 3;     // Mode: pin B filter enable
  localparam int TCC_BIT_FILT_A = 2;     // Mode: pin_a_filter_enable
  localparam int TCC_BIT_PWM = 0;        // Mode: pwm_mode_select
  localparam int TCC_BIT_CAP_B = 6;      // Pin io: unit B capture mode
  localparam int TCC_BIT_ACT_B = 4;      // Pin io: unit B action, two bits
  localparam int TCC_BIT_CAP_A = 2;      // Pin io: unit_a_capture_mode
  localparam int TCC_BIT_ACT_A = 0;      // Pin io: unit A action, two bits
  localparam int TCC_BIT_OVF = 3;        // Overflow flag / enable
  localparam int TCC_BIT_UDF = 2;        // Underflow flag / enable
  localparam int TCC_BIT_TIMER_IRQ = 3;  // Request, mask and priority bit
  localparam int TCC_BIT_SUPPLY = 6;     // timer_clock_supply_enable

  // Values after reset
  localparam logic TCC_RST_MASK = 1'b1;       // Servicing blocked
  localparam logic TCC_RST_PRIO = 1'b1;       // Level 3, lowest
  localparam logic [15:0] TCC_RST_GEN = 16'hffff;
  localparam int TCC_FILT_SAMPLES = 3;        // Equal samples to accept a level

  // Counter clock source codes
  typedef enum logic [2:0] {
    TCC_CK_DIV1 = 3'h0,
    TCC_CK_DIV2 = 3'h1,
    TCC_CK_DIV4 = 3'h2,
    TCC_CK_DIV8 = 3'h3,
    TCC_CK_DIV32 = 3'h4,
    TCC_CK_EXT_A = 3'h5,
    TCC_CK_EXT_B = 3'h7
  } tcc_cnt_src_t;

  // Software configuration of the timer
  typedef struct packed {
    logic [2:0] cnt_sel;   // Count clock select
    logic run;             // Counting enabled
    logic [1:0] filt_sel;  // Filter clock select
    logic [1:0] filt_en;   // {B, A} filter enables
    logic pwm;             // PWM mode, pins released
    logic [1:0] cap_mode;  // {B, A} capture mode
    logic [3:0] action;    // {B[1:0], A[1:0]} edge / match code
    logic [3:0] irq_en;    // Overflow, underflow, B, A
  } tcc_cfg_t;

  // Status flags in their register order
  typedef struct packed {
    logic ovf;   // overflow_flag
    logic udf;   // underflow_flag
    logic imfb;  // unit_b_match_flag
    logic imfa;  // unit_a_match_flag
  } tcc_flags_t;

endpackage : tcc_pkg

// ==== hdl/tcc_timer.sv ====
// Timer capture/compare unit with APB register slave and two pins.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
module tcc_timer
  import tcc_pkg::*;
(
  input wire logic clk_in, // Peripheral clock, 200 MHz
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB write
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  input wire logic [3:0] pstrb_in, // APB byte strobes
  output logic pready_out, // APB ready
  output logic [31:0] prdata_out, // APB read data
  output logic pslverr_out, // APB error, unmapped address
  input wire logic pin_a_in, // capture_compare_pin_a level
  output logic pin_a_out, // Pin A drive level
  output logic pin_a_oe_n_out, // Pin A enable, low drives
  input wire logic pin_b_in, // capture_compare_pin_b level
  output logic pin_b_out, // Pin B drive level
  output logic pin_b_oe_n_out, // Pin B enable, low drives
  input wire logic ext_clock_in_a_in, // External count clock A
  input wire logic ext_clock_in_b_in, // External count clock B
  output logic timer_interrupt_out, // Request and not masked
  output logic [1:0] timer_priority_out // {hi, lo} priority level
);

  // Edge test of a capture code against detected rising and falling edges
  function automatic logic edge_hit(input logic [1:0] code, input logic rise,
                                    input logic fall);
    case (code)
      2'b00: return rise;
      2'b01: return fall;
      2'b10: return rise | fall;
      default: return 1'b0;  // Prohibited code catches nothing
    endcase
  endfunction
  // Address decode, used for both error answer and write enable
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr <= TCC_OFS_SUPPLY) && (addr[1:0] == 2'b00);
  endfunction
  // Synchronisers: {ext B, ext A, pin B, pin A}
  logic [3:0] sync1;        // First stage, read only by the second
  logic [3:0] sync2;        // Second stage, safe to use
  logic [1:0] ext_prev;     // Previous synced external clock levels

  // Timer state
  tcc_cfg_t cfg, next_cfg;             // Software configuration
  tcc_flags_t flags, next_flags;       // Status flags
  logic supply, next_supply;           // Clock supply enable
  logic [15:0] cnt, next_cnt;          // main_counter
  logic [15:0] gen [2];                // General registers A and B
  logic [15:0] next_gen [2];
  logic [4:0] div, next_div;           // Free running prescaler
  logic [1:0] matched, next_matched;   // First match seen per unit
  logic [1:0] pin_lvl, next_pin_lvl;   // Compare output level per unit
  logic [1:0] pin_oe_n, next_pin_oe_n; // Pin enables, low drives
  logic irq_req, next_irq_req;         // timer_irq_request
  logic irq_mask, next_irq_mask;       // timer_irq_mask
  logic prio_hi, next_prio_hi;         // timer_priority_hi
  logic prio_lo, next_prio_lo;         // timer_priority_lo
  logic irq_out, next_irq_out;         // Registered interrupt output
  logic pready, next_pready;           // APB ready
  logic [31:0] prdata, next_prdata;    // APB read data
  logic pslverr, next_pslverr;         // APB error

  // Filter and edge state per unit
  logic [TCC_FILT_SAMPLES-1:0] samp [2];  // Sample history at filter tick
  logic [1:0] filt_lvl;                   // Accepted filtered level
  logic [1:0] in_prev;                    // Level seen last cycle
  logic [1:0] in_now;                     // Level after optional filter
  logic [1:0] cap_evt;                    // Valid capture edge per unit

  logic cnt_tick;   // One counting step
  logic filt_tick;  // One filter sample
  logic ext_a_rise; // Rising edge of external clock A
  logic ext_b_rise; // Rising edge of external clock B

  // Two-flop synchronisers for every asynchronous input
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      ext_prev <= 2'h0;
    end
    else
    begin
      sync1 <= {ext_clock_in_b_in, ext_clock_in_a_in, pin_b_in, pin_a_in};
      sync2 <= sync1;
      ext_prev <= sync2[3:2];
    end
  end

  assign ext_a_rise = sync2[2] & ~ext_prev[0];
  assign ext_b_rise = sync2[3] & ~ext_prev[1];

  // Count clock selection from prescaler taps and external edges
  always_comb
  begin
    case (tcc_cnt_src_t'(cfg.cnt_sel))  // [RQ1]
      TCC_CK_DIV1: cnt_tick = 1'b1;
      TCC_CK_DIV2: cnt_tick = div[0];
      TCC_CK_DIV4: cnt_tick = &div[1:0];
      TCC_CK_DIV8: cnt_tick = &div[2:0];
      TCC_CK_DIV32: cnt_tick = &div[4:0];
      TCC_CK_EXT_A: cnt_tick = ext_a_rise;
      TCC_CK_EXT_B: cnt_tick = ext_b_rise;
      default: cnt_tick = 1'b0;  // Prohibited code stalls counting
    endcase
  end

  // Filter sampling clock selection
  always_comb
  begin
    case (cfg.filt_sel)  // [RQ2]
      2'b00: filt_tick = &div[4:0];
      2'b01: filt_tick = &div[2:0];
      2'b10: filt_tick = 1'b1;
      default: filt_tick = cnt_tick;
    endcase
  end

  // Per-unit digital filter and edge detector
  genvar u;
  generate
    for (u = 0; u < 2; u++)
    begin : g_unit
      logic [TCC_FILT_SAMPLES-1:0] next_samp;  // Next sample history
      logic next_filt;                         // Next filtered level
      logic rise;                              // Rising edge seen
      logic fall;                              // Falling edge seen
      // Accept a new level only after three equal samples
      always_comb
      begin
        next_samp = samp[u];
        next_filt = filt_lvl[u];
        if (filt_tick)
          next_samp = {samp[u][TCC_FILT_SAMPLES-2:0], sync2[u]};
        if (&samp[u])  // [RQ3]
          next_filt = 1'b1;
        else if (~|samp[u])
          next_filt = 1'b0;
      end
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in || !supply)
        begin
          samp[u] <= '0;
          filt_lvl[u] <= 1'b0;
          in_prev[u] <= sync2[u];  // Track the pin, so a high idle pin gives no false edge
        end
        else
        begin
          samp[u] <= next_samp;
          filt_lvl[u] <= next_filt;
          in_prev[u] <= in_now[u];
        end
      end

      // Filter bypassed when its enable is clear
      assign in_now[u] = cfg.filt_en[u] ? filt_lvl[u] : sync2[u];  // [RQ3]
      assign rise = in_now[u] & ~in_prev[u];
      assign fall = ~in_now[u] & in_prev[u];
      // Capture only in timer mode with the unit set for capture
      assign cap_evt[u] = ~cfg.pwm & cfg.cap_mode[u]  // [RQ6] [RQ11]
                          & edge_hit(cfg.action[2*u +: 2], rise, fall);  // [RQ7]
    end
  endgenerate

  // Next state of counter, units, flags, interrupt and APB slave
  always_comb
  begin
    logic wr;             // APB write completes this cycle
    logic rd;             // APB read data sampled this cycle
    logic tmr_wr;         // Write to a timer register is allowed
    logic [1:0] act;      // Unit action code
    logic [1:0] match;    // Compare match per unit
    logic [15:0] inc;     // Counter plus one
    tcc_flags_t set_evt;  // Flags raised this cycle
    logic [31:0] rdv;     // Read value
    wr = 1'b0;
    rd = 1'b0;
    tmr_wr = 1'b0;
    act = 2'b00;
    match = 2'b00;
    inc = cnt + 16'h0001;
    set_evt = '0;
    rdv = 32'h0000_0000;
    next_cfg = cfg;
    next_flags = flags;
    next_supply = supply;
    next_cnt = cnt;
    next_gen = gen;
    next_div = div + 5'h01;
    next_matched = matched;
    next_pin_lvl = pin_lvl;
    next_pin_oe_n = pin_oe_n;
    next_irq_req = irq_req;
    next_irq_mask = irq_mask;
    next_prio_hi = prio_hi;
    next_prio_lo = prio_lo;
    // APB: one wait state, write lands at the pready edge
    wr = psel_in & penable_in & pready & pwrite_in & pstrb_in[0] & is_mapped(paddr_in);
    rd = psel_in & penable_in & ~pready;
    tmr_wr = wr & supply;  // [RQ20]
    next_pready = psel_in & penable_in & ~pready;
    next_pslverr = rd & ~is_mapped(paddr_in);
    // Software writes, ahead of hardware so that hardware events win
    if (tmr_wr)
    begin
      if (paddr_in == TCC_OFS_CONTROL)
        next_cfg.cnt_sel = pwdata_in[2:0];
      else if (paddr_in == TCC_OFS_MODE)
      begin
        next_cfg.run = pwdata_in[TCC_BIT_RUN];
        next_cfg.filt_sel = pwdata_in[TCC_BIT_FILT_SEL +: 2];
        next_cfg.filt_en = {pwdata_in[TCC_BIT_FILT_B], pwdata_in[TCC_BIT_FILT_A]};
        next_cfg.pwm = pwdata_in[TCC_BIT_PWM];
      end
      else if (paddr_in == TCC_OFS_PIN_IO)
      begin
        next_cfg.cap_mode = {pwdata_in[TCC_BIT_CAP_B], pwdata_in[TCC_BIT_CAP_A]};
        next_cfg.action = {pwdata_in[TCC_BIT_ACT_B +: 2], pwdata_in[TCC_BIT_ACT_A +: 2]};
      end
      else if (paddr_in == TCC_OFS_IRQ_EN)
        next_cfg.irq_en = pwdata_in[3:0];
      else if (paddr_in == TCC_OFS_STATUS)
        next_flags = flags & tcc_flags_t'(pwdata_in[3:0]);  // Zero clears, one keeps
      else if (paddr_in == TCC_OFS_GEN_A)
        next_gen[0] = {pstrb_in[1] ? pwdata_in[15:8] : gen[0][15:8], pwdata_in[7:0]};
      else if (paddr_in == TCC_OFS_GEN_B)
        next_gen[1] = {pstrb_in[1] ? pwdata_in[15:8] : gen[1][15:8], pwdata_in[7:0]};
      else if (paddr_in == TCC_OFS_COUNTER)
        next_cnt = {pstrb_in[1] ? pwdata_in[15:8] : cnt[15:8], pwdata_in[7:0]};
    end
    // Interrupt controller bits sit outside the timer's clock gate
    if (wr)
    begin
      if (paddr_in == TCC_OFS_IRQ_REQ)
        next_irq_req = pwdata_in[TCC_BIT_TIMER_IRQ];
      else if (paddr_in == TCC_OFS_IRQ_MASK)
        next_irq_mask = pwdata_in[TCC_BIT_TIMER_IRQ];
      else if (paddr_in == TCC_OFS_PRIO_HI)
        next_prio_hi = pwdata_in[TCC_BIT_TIMER_IRQ];
      else if (paddr_in == TCC_OFS_PRIO_LO)
        next_prio_lo = pwdata_in[TCC_BIT_TIMER_IRQ];
      else if (paddr_in == TCC_OFS_SUPPLY)
        next_supply = pwdata_in[TCC_BIT_SUPPLY];  // [RQ20]
    end
    // Counting; underflow stays clear since only up-counting exists
    if (cfg.run && cnt_tick)  // [RQ5]
    begin
      next_cnt = inc;
      set_evt.ovf = (cnt == 16'hffff);  // [RQ21]
      for (int i = 0; i < 2; i++)
        match[i] = ~cfg.pwm & ~cfg.cap_mode[i] & (inc == gen[i]);  // [RQ10]
    end
    // Pin output per unit; PWM mode releases both pins
    for (int i = 0; i < 2; i++)
    begin
      act = cfg.action[2*i +: 2];
      next_pin_oe_n[i] = cfg.pwm | cfg.cap_mode[i] | (act == 2'b00);  // [RQ11]
      if (match[i])
      begin
        next_matched[i] = 1'b1;
        case (act)  // [RQ19]
          2'b01: next_pin_lvl[i] = 1'b0;
          2'b10: next_pin_lvl[i] = 1'b1;
          2'b11: next_pin_lvl[i] = ~pin_lvl[i];
          default: next_pin_lvl[i] = pin_lvl[i];
        endcase
      end
      else if (!matched[i])
        next_pin_lvl[i] = (act == 2'b01);  // [RQ9]
      if (cap_evt[i])
        next_gen[i] = cnt;  // [RQ8]
    end
    set_evt.imfa = match[0] | cap_evt[0];
    set_evt.imfb = match[1] | cap_evt[1];
    // Hardware sets win over a clearing write in the same cycle
    next_flags = next_flags | set_evt;
    if (|(set_evt & tcc_flags_t'(cfg.irq_en)))  // [RQ13] [RQ14] [RQ15]
      next_irq_req = 1'b1;  // [RQ16]
    next_irq_out = irq_req & ~irq_mask;  // [RQ17]
    // Read mux; timer registers read zero while the clock is gated
    if (paddr_in == TCC_OFS_IRQ_REQ)
      rdv[TCC_BIT_TIMER_IRQ] = irq_req;
    else if (paddr_in == TCC_OFS_IRQ_MASK)
      rdv[TCC_BIT_TIMER_IRQ] = irq_mask;
    else if (paddr_in == TCC_OFS_PRIO_HI)
      rdv[TCC_BIT_TIMER_IRQ] = prio_hi;
    else if (paddr_in == TCC_OFS_PRIO_LO)
      rdv[TCC_BIT_TIMER_IRQ] = prio_lo;
    else if (paddr_in == TCC_OFS_SUPPLY)
      rdv[TCC_BIT_SUPPLY] = supply;
    else if (!supply)
      rdv = 32'h0;  // [RQ20]
    else if (paddr_in == TCC_OFS_CONTROL)
      rdv[2:0] = cfg.cnt_sel;
    else if (paddr_in == TCC_OFS_MODE)
    begin
      rdv[TCC_BIT_RUN] = cfg.run;
      rdv[TCC_BIT_FILT_SEL +: 2] = cfg.filt_sel;
      rdv[TCC_BIT_FILT_B] = cfg.filt_en[1];
      rdv[TCC_BIT_FILT_A] = cfg.filt_en[0];
      rdv[TCC_BIT_PWM] = cfg.pwm;
    end
    else if (paddr_in == TCC_OFS_PIN_IO)
    begin
      rdv[TCC_BIT_CAP_B] = cfg.cap_mode[1];
      rdv[TCC_BIT_ACT_B +: 2] = cfg.action[3:2];
      rdv[TCC_BIT_CAP_A] = cfg.cap_mode[0];
      rdv[TCC_BIT_ACT_A +: 2] = cfg.action[1:0];
    end
    else if (paddr_in == TCC_OFS_IRQ_EN)
      rdv[3:0] = cfg.irq_en;
    else if (paddr_in == TCC_OFS_STATUS)
      rdv[3:0] = flags;
    else if (paddr_in == TCC_OFS_GEN_A)
      rdv[15:0] = gen[0];
    else if (paddr_in == TCC_OFS_GEN_B)
      rdv[15:0] = gen[1];
    else if (paddr_in == TCC_OFS_COUNTER)
      rdv[15:0] = cnt;
    next_prdata = (rd && !pwrite_in) ? rdv : 32'h0;
  end

  // Registers; a cleared supply bit holds the timer itself in reset
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      supply <= 1'b0;
      irq_req <= 1'b0;
      irq_mask <= TCC_RST_MASK;
      prio_hi <= TCC_RST_PRIO;
      prio_lo <= TCC_RST_PRIO;
      irq_out <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      supply <= next_supply;
      irq_req <= next_irq_req;
      irq_mask <= next_irq_mask;
      prio_hi <= next_prio_hi;
      prio_lo <= next_prio_lo;
      irq_out <= next_irq_out;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
    if (!rst_n_in || !supply)  // [RQ20]
    begin
      cfg <= '0;
      flags <= '0;
      cnt <= 16'h0000;
      gen[0] <= TCC_RST_GEN;
      gen[1] <= TCC_RST_GEN;
      div <= 5'h00;
      matched <= 2'b00;
      pin_lvl <= 2'b00;
      pin_oe_n <= 2'b11;
    end
    else
    begin
      cfg <= next_cfg;
      flags <= next_flags;
      cnt <= next_cnt;
      gen <= next_gen;
      div <= next_div;
      matched <= next_matched;
      pin_lvl <= next_pin_lvl;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // Outputs straight from flip-flops
  assign pready_out = pready;
  assign prdata_out = prdata;
  assign pslverr_out = pslverr;
  assign pin_a_out = pin_lvl[0];
  assign pin_a_oe_n_out = pin_oe_n[0];
  assign pin_b_out = pin_lvl[1];
  assign pin_b_oe_n_out = pin_oe_n[1];
  assign timer_interrupt_out = irq_out;
  assign timer_priority_out = {prio_hi, prio_lo};  // [RQ18]

endmodule // tcc_timer

// ==== tb/tcc_pin_model.sv ====
// Far-side model: external signals on the two timer pins and count clocks.
module tcc_pin_model
(
  input wire logic clk_in,   // Bench clock
  input wire logic lvl_a_in, // Wanted level on pin A
  input wire logic lvl_b_in, // Wanted level on pin B
  input wire logic slow_in,  // Answer after four cycles, not one
  output logic pin_a_out,    // Level on pin A
  output logic pin_b_out,    // Level on pin B
  output logic ext_a_out,    // External count clock A
  output logic ext_b_out     // External count clock B
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] dly_a = 4'h0; // Pin A level history
  logic [3:0] dly_b = 4'hf; // Pin B history, pulled up
  logic [3:0] div = 4'h0;   // Divider for the count clocks
  // Slow answers let the synchroniser see late edges
  always @(posedge clk_in)
  begin
    dly_a <= {dly_a[2:0], lvl_a_in};
    dly_b <= {dly_b[2:0], lvl_b_in};
    div <= div + 4'h1;
  end
  assign pin_a_out = slow_in ? dly_a[3] : dly_a[0];
  assign pin_b_out = slow_in ? dly_b[3] : dly_b[0];
  assign ext_a_out = div[1];
  assign ext_b_out = div[3];
endmodule // tcc_pin_model

// ==== tb/tcc_timer_props.sv ====
// Port-level checker of the timer capture/compare unit, with its bind.
module tcc_timer_props
  import tcc_pkg::*;
(
  input wire logic clk_in,                  // Clock
  input wire logic rst_n_in,                // Reset, active low
  input wire logic psel_in,                 // APB select
  input wire logic penable_in,              // APB enable
  input wire logic [7:0] paddr_in,          // APB address
  input wire logic pready_out,              // APB ready
  input wire logic [31:0] prdata_out,       // Read data
  input wire logic pslverr_out,             // Error response
  input wire logic pin_a_oe_n_out,          // Pin A enable
  input wire logic pin_b_oe_n_out,          // Pin B enable
  input wire logic timer_interrupt_out,     // Interrupt
  input wire logic [1:0] timer_priority_out // Priority level
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Access phase still waiting for its answer
  sequence wait_s;
    psel_in && penable_in && !pready_out;
  endsequence
  // Access phase that completes at this edge
  sequence done_s;
    psel_in && penable_in && pready_out;
  endsequence
  ready_delay_a: assert property (wait_s |=> pready_out) else $error("ready late");
  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready too long");
  ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0) else $error("rdata idle");
  // Addresses above the supply register are unmapped
  unmapped_err_a: assert property ((done_s ##0 paddr_in > 8'h30) |-> pslverr_out)
    else $error("no error on unmapped");
  mapped_ok_a: assert property ((done_s ##0 (paddr_in <= 8'h30 && paddr_in[1:0] == 2'h0))
    |-> !pslverr_out) else $error("error on mapped");
  reset_pins_a: assert property ($rose(rst_n_in) |-> pin_a_oe_n_out && pin_b_oe_n_out)
    else $error("pins driven after reset");
  reset_irq_a: assert property ($rose(rst_n_in) |-> !timer_interrupt_out &&
    timer_priority_out == 2'h3) else $error("irq state after reset");
endmodule // tcc_timer_props

bind tcc_timer tcc_timer_props chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out), .pin_a_oe_n_out(pin_a_oe_n_out),
  .pin_b_oe_n_out(pin_b_oe_n_out), .timer_interrupt_out(timer_interrupt_out),
  .timer_priority_out(timer_priority_out));

// ==== tb/testbench.sv ====
// Self-checking bench of the timer capture/compare unit.
module testbench
  import tcc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, irq, slow, lvl_a, lvl_b;
  logic pa_o, pa_oe_n, pb_o, pb_oe_n, ma, mb, ea, eb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] prio;
  logic [64:0] exp_q[$]; // {mask, error, data} per transfer
  logic [64:0] ent;
  logic [15:0] val, capt;
  int miscompares, cmp_count, cycles, seed, c, k, n;
  wire pa_w = pa_oe_n ? ma : pa_o; // Pin wire levels
  wire pb_w = pb_oe_n ? mb : pb_o;
  tcc_timer dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .pin_a_in(pa_w),
    .pin_a_out(pa_o), .pin_a_oe_n_out(pa_oe_n), .pin_b_in(pb_w), .pin_b_out(pb_o),
    .pin_b_oe_n_out(pb_oe_n), .ext_clock_in_a_in(ea), .ext_clock_in_b_in(eb),
    .timer_interrupt_out(irq), .timer_priority_out(prio));
  tcc_pin_model model_u (.clk_in(clk_in), .lvl_a_in(lvl_a), .lvl_b_in(lvl_b), .slow_in(slow),
    .pin_a_out(ma), .pin_b_out(mb), .ext_a_out(ea), .ext_b_out(eb));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the expected answer is noted before the request goes out
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({m, e, d});
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask
  // Answer watcher and hang guard
  always @(posedge clk_in)
  begin
    if (rst_n_in && pready === 1'b1)
    begin
      ent = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      chk("rdata", ent[31:0] & ent[64:33], prdata & ent[64:33]);
      chk("slverr", {31'h0, ent[32]}, {31'h0, pslverr});
    end
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rst_n_in, lvl_a, slow} = '0;
    lvl_b = 1'b1;
    seed = 61;
    capt = TCC_RST_GEN;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(TCC_OFS_GEN_A, 32'h1234);
    bus(1'b0, TCC_OFS_GEN_A, 32'h0, '1, 1'b0);
    bus(1'b0, TCC_OFS_IRQ_MASK, 32'h8, '1, 1'b0);
    bus(1'b0, TCC_OFS_PRIO_LO, 32'h8, '1, 1'b0);
    bus(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    wr(TCC_OFS_SUPPLY, 32'h40);
    bus(1'b0, TCC_OFS_GEN_A, {16'h0, TCC_RST_GEN}, '1, 1'b0);
    $display("test reset done");
    // Capture with the counter held, every edge code, last one filtered
    for (c = 0; c < 3; c++)
    begin
      wr(TCC_OFS_MODE, c == 2 ? 32'h24 : 32'h0);
      wr(TCC_OFS_PIN_IO, 32'h4 | 32'(c));
      for (k = 0; k < 2; k++)
      begin
        val = 16'($random(seed));
        wr(TCC_OFS_COUNTER, {16'h0, val});
        slow <= k[0];
        lvl_a <= ~lvl_a;
        repeat (20) @(posedge clk_in);
        if (c == 2 || c == k)
          capt = val;
        bus(1'b0, TCC_OFS_GEN_A, {16'h0, capt}, '1, 1'b0);
      end
    end
    $display("test capture done");
    // Unit B match actions: toggle, low, high
    for (k = 0; k < 3; k++)
    begin
      c = (k + 2) % 3 + 1;
      wr(TCC_OFS_MODE, 32'h0);
      wr(TCC_OFS_PIN_IO, 32'(c) << 4);
      wr(TCC_OFS_GEN_B, 32'h10);
      wr(TCC_OFS_COUNTER, 32'h0);
      wr(TCC_OFS_MODE, 32'h80);
      repeat (40) @(posedge clk_in);
      chk("pin_b", {31'h0, c != 1}, {30'h0, pb_oe_n, pb_o});
    end
    $display("test unit b done");
    // Unit A: level before match, match, interrupt, mask
    wr(TCC_OFS_MODE, 32'h0);
    wr(TCC_OFS_PIN_IO, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("pin_a idle", 32'h1, {30'h0, pa_oe_n, pa_o});
    wr(TCC_OFS_GEN_A, 32'h20);
    wr(TCC_OFS_COUNTER, 32'h0);
    wr(TCC_OFS_STATUS, 32'h0);
    wr(TCC_OFS_IRQ_REQ, 32'h0);
    wr(TCC_OFS_IRQ_MASK, 32'h0);
    wr(TCC_OFS_IRQ_EN, 32'h1);
    wr(TCC_OFS_CONTROL, 32'h0);
    wr(TCC_OFS_MODE, 32'h80);
    wait_irq();
    chk("irq a", 32'h1, {31'h0, irq});
    chk("pin_a", 32'h0, {31'h0, pa_w});
    bus(1'b0, TCC_OFS_IRQ_REQ, 32'h8, 32'h8, 1'b0);
    wr(TCC_OFS_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clk_in);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test compare done");
    // Overflow wrap raises the interrupt through its own enable
    wr(TCC_OFS_MODE, 32'h0);
    wr(TCC_OFS_IRQ_EN, 32'h8);
    wr(TCC_OFS_STATUS, 32'h0);
    wr(TCC_OFS_IRQ_REQ, 32'h0);
    wr(TCC_OFS_IRQ_MASK, 32'h0);
    wr(TCC_OFS_COUNTER, 32'hfff0);
    wr(TCC_OFS_MODE, 32'h80);
    wait_irq();
    chk("irq ovf", 32'h1, {31'h0, irq});
    bus(1'b0, TCC_OFS_STATUS, 32'h8, 32'h8, 1'b0);
    for (c = 0; c < 4; c++)
    begin
      wr(TCC_OFS_PRIO_HI, 32'(c / 2) << 3);
      wr(TCC_OFS_PRIO_LO, 32'(c % 2) << 3);
      repeat (2) @(posedge clk_in);
      chk("prio", 32'(c), {30'h0, prio});
    end
    $display("test interrupt done");
    repeat (4) @(posedge clk_in);
    complete_run();
  end
endmodule // testbench
